// >>> rtl/ssr_pkg.sv
package ssr_pkg;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 4;
   localparam int DEPTH = 16;
   localparam int BURST_LEN = 4;
   localparam int FIFO_DEPTH = 2;
   localparam logic [2:0] BURST_CNT_RST = 3'h0;
   localparam logic [1:0] FIFO_CNT_RST = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

   typedef struct packed {
      logic [DATA_W-1:0] data;
   } ssr_word_t;

   typedef struct packed {
      logic k;
      logic k_n;
      logic c;
      logic c_n;
      logic sel_n;
   } ssr_link_t;

   // idle pin levels, so the edge finders see no false strobe after reset
   localparam ssr_link_t LINK_RST = 5'h0B;

   typedef enum logic [0:0] {
      SSR_IDLE,
      SSR_BURST
   } ssr_state_t;
endpackage : ssr_pkg

// >>> rtl/ssr_read_port.sv
`timescale 1ns/1ps
module ssr_read_port
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire ssr_pkg::ssr_link_t link_i,
   input wire logic [ssr_pkg::ADDR_W-1:0] addr_i,
   input wire logic single_clk_mode_i,
   input wire logic load_en_i,
   input wire logic [ssr_pkg::ADDR_W-1:0] load_addr_i,
   input wire ssr_pkg::ssr_word_t load_data_i,
   output logic [ssr_pkg::DATA_W-1:0] q_o,
   output logic q_oe_o
);
   import ssr_pkg::*;

   // ****************************************
   // input synchronisers
   // ****************************************
   ssr_link_t link_s1_r;
   ssr_link_t link_s2_r;
   ssr_link_t link_s3_r;
   logic [ADDR_W-1:0] addr_s1_r;
   logic [ADDR_W-1:0] addr_s2_r;
   logic mode_s1_r;
   logic mode_s2_r;

   // the address rides the same two stages so it lines up with the clock edge
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         link_s1_r <= LINK_RST;
         link_s2_r <= LINK_RST;
         link_s3_r <= LINK_RST;
         addr_s1_r <= ADDR_RST;
         addr_s2_r <= ADDR_RST;
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
      end
      else
      begin
         link_s1_r <= link_i;
         link_s2_r <= link_s1_r;
         link_s3_r <= link_s2_r;
         addr_s1_r <= addr_i;
         addr_s2_r <= addr_s1_r;
         mode_s1_r <= single_clk_mode_i;
         mode_s2_r <= mode_s1_r;
      end
   end

   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction : rise

   function automatic logic burst_last(input logic [2:0] cnt);
      burst_last = (cnt == 3'(BURST_LEN - 1));
   endfunction : burst_last

   logic k_rise;
   logic pos_strobe;
   logic any_strobe;
   always_comb
   begin
      k_rise = rise(link_s2_r.k, link_s3_r.k);
      if (mode_s2_r)
      begin
         pos_strobe = k_rise;
         any_strobe = k_rise | rise(link_s2_r.k_n, link_s3_r.k_n);
      end
      else
      begin
         pos_strobe = rise(link_s2_r.c, link_s3_r.c);
         any_strobe = pos_strobe | rise(link_s2_r.c_n, link_s3_r.c_n);
      end
   end

   // ****************************************
   // array
   // ****************************************
   ssr_word_t mem_r [DEPTH];

   always_ff @(posedge clk_i)
   begin
      if (load_en_i)
      begin
         mem_r[load_addr_i] <= load_data_i;
      end
   end

   // ****************************************
   // request capture
   // ****************************************
   logic req;
   logic pend_r;
   logic [ADDR_W-1:0] pend_addr_r;
   ssr_state_t state_r;
   logic [2:0] cnt_r;
   logic [ADDR_W-1:0] rd_addr_r;
   logic push;
   logic fifo_ready;

   assign req = k_rise & ~link_s2_r.sel_n;

   logic take_pend;
   assign take_pend = (state_r == SSR_IDLE) |
      (push & burst_last(cnt_r));

   // one request may wait behind a running burst; bursts never overlap
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pend_r <= 1'b0;
         pend_addr_r <= ADDR_RST;
      end
      else if (req)
      begin
         pend_r <= 1'b1;
         pend_addr_r <= addr_s2_r;
      end
      else if (pend_r & take_pend)
      begin
         pend_r <= 1'b0;
      end
   end

   // ****************************************
   // burst reader
   // ****************************************
   assign push = (state_r == SSR_BURST) & fifo_ready;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_r <= SSR_IDLE;
         cnt_r <= BURST_CNT_RST;
         rd_addr_r <= ADDR_RST;
      end
      else
      begin
         case (state_r)
            SSR_IDLE:
            begin
               if (pend_r)
               begin
                  state_r <= SSR_BURST;
                  cnt_r <= BURST_CNT_RST;
                  rd_addr_r <= pend_addr_r;
               end
            end
            SSR_BURST:
            begin
               if (push)
               begin
                  rd_addr_r <= rd_addr_r + 4'h1;
                  cnt_r <= cnt_r + 3'h1;
                  if (burst_last(cnt_r))
                  begin
                     if (pend_r)
                     begin
                        cnt_r <= BURST_CNT_RST;
                        rd_addr_r <= pend_addr_r;
                     end
                     else
                     begin
                        state_r <= SSR_IDLE;
                     end
                  end
               end
            end
            default:
            begin
               state_r <= SSR_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // two-entry buffer
   // ****************************************
   ssr_word_t fifo_r [FIFO_DEPTH];
   logic [1:0] fifo_cnt_r;
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic fifo_valid;
   logic pop;

   assign fifo_ready = (fifo_cnt_r != 2'(FIFO_DEPTH));
   assign fifo_valid = (fifo_cnt_r != FIFO_CNT_RST);
   assign pop = any_strobe & fifo_valid;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         fifo_cnt_r <= FIFO_CNT_RST;
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop)
         begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push & ~pop)
         begin
            fifo_cnt_r <= fifo_cnt_r + 2'h1;
         end
         else if (pop & ~push)
         begin
            fifo_cnt_r <= fifo_cnt_r - 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         fifo_r[wr_ptr_r] <= mem_r[rd_addr_r];
      end
   end

   // ****************************************
   // output launch
   // ****************************************
   logic busy;
   assign busy = pend_r | (state_r == SSR_BURST) | fifo_valid;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q_o <= DATA_RST;
         q_oe_o <= 1'b0;
      end
      else if (pop)
      begin
         q_o <= fifo_r[rd_ptr_r].data;
         q_oe_o <= 1'b1;
      end
      else if (pos_strobe & ~busy)
      begin
         q_oe_o <= 1'b0;
      end
   end
endmodule : ssr_read_port

// >>> tb/ssr_ctrl_model.sv
`timescale 1ns/1ps
module ssr_ctrl_model
(
   output ssr_pkg::ssr_link_t link_o,
   output logic [ssr_pkg::ADDR_W-1:0] addr_o
);
   import ssr_pkg::*;
   int left = 0;
   initial link_o = 5'h0B;
   initial addr_o = 4'h0;
   // ****
   // strobes run only in a frame; c lags k
   // ****
   always
   begin
      wait (left > 0);
      link_o[4:3] = 2'h2;
      #40 link_o[2:1] = 2'h2;
      #120 link_o[4:3] = 2'h1;
      #40 link_o[2:1] = 2'h1;
      #120 left = left - 1;
   end
   task automatic req(input logic [ADDR_W-1:0] a);
      #40 link_o.sel_n = 1'b0;
      addr_o = a;
      // each read adds periods, so a queued burst still sees a c rise to release on
      #40 left = left + 4;
      @(negedge link_o.k);
      link_o.sel_n = 1'b1;
      addr_o = ~a;
   endtask : req
endmodule : ssr_ctrl_model

// >>> tb/ssr_read_port_sva.sv
`timescale 1ns/1ps
module ssr_read_port_sva
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire ssr_pkg::ssr_link_t link_i,
   input wire logic single_clk_mode_i,
   input wire logic [ssr_pkg::DATA_W-1:0] q_o,
   input wire logic q_oe_o
);
   import ssr_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // ****
   // checks
   // ****
   a_rst_quiet: assert property ($rose(arst_n_i) |-> q_o == '0 && !q_oe_o)
      else $error("outputs live after reset");
   a_q_hold: assert property ($stable(link_i[4:1])[*6] |=> $stable(q_o))
      else $error("word moved without strobe");
   a_oe_hold: assert property ($stable(link_i[4:1])[*6] |=> $stable(q_oe_o))
      else $error("enable moved without strobe");
   a_q_needs_oe: assert property ($changed(q_o) |-> q_oe_o)
      else $error("word changed while released");
   a_burst_whole: assert property ($rose(q_oe_o) |-> q_oe_o[*8])
      else $error("burst cut short");
   a_word_gap: assert property ($changed(q_o) |=> $stable(q_o)[*2])
      else $error("words too close");
   a_oe_off_pos: assert property ($fell(q_oe_o) |->
      (single_clk_mode_i ? $past(link_i.k, 2) : $past(link_i.c, 2)))
      else $error("release not after positive strobe");
   a_oe_on_strobe: assert property ($rose(q_oe_o) |-> (single_clk_mode_i ?
      $past(link_i.k, 2) || $past(link_i.k_n, 2) : $past(link_i.c, 2) || $past(link_i.c_n, 2)))
      else $error("drive not on strobe");
endmodule : ssr_read_port_sva
bind ssr_read_port ssr_read_port_sva chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .link_i(link_i), .single_clk_mode_i(single_clk_mode_i), .q_o(q_o), .q_oe_o(q_oe_o));

// >>> tb/ssr_read_port_tb.sv
`timescale 1ns/1ps
module ssr_read_port_tb;
   import ssr_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic single_clk_mode_i = 1'b0;
   logic load_en_i = 1'b0;
   logic [ADDR_W-1:0] load_addr_i = 4'h0;
   ssr_word_t load_data_i = 18'h00000;
   ssr_link_t link_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] q_o;
   logic q_oe_o;
   logic [DATA_W-1:0] last_q = 18'h00000;
   logic [DATA_W-1:0] got[$];
   int num_errors = 0;
   int n_checks = 0;
   always #20 clk_i = ~clk_i;
   ssr_ctrl_model ctrl (.link_o(link_i), .addr_o(addr_i));
   ssr_read_port uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_i(link_i), .addr_i(addr_i),
      .single_clk_mode_i(single_clk_mode_i), .load_en_i(load_en_i),
      .load_addr_i(load_addr_i), .load_data_i(load_data_i), .q_o(q_o), .q_oe_o(q_oe_o));
   // ****
   // capture each new word while driven
   // ****
   always @(negedge clk_i)
   begin
      if (q_oe_o === 1'b1 && q_o !== last_q)
         got.push_back(q_o);
      last_q = q_o;
   end
   function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
      return {14'h2C35, a};
   endfunction : pat
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic expect_words(input logic [ADDR_W-1:0] a, input int n);
      repeat (64) @(negedge clk_i);
      chk(DATA_W'(got.size()), DATA_W'(n));
      for (int i = 0; i < n; i++)
         chk(got[i], pat(ADDR_W'(a + i)));
      chk(DATA_W'(q_oe_o), 18'h00000);
      got.delete();
   endtask : expect_words
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #50000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b1;
      for (int i = 0; i < DEPTH; i++)
      begin
         @(negedge clk_i);
         load_en_i = 1'b1;
         load_addr_i = ADDR_W'(i);
         load_data_i = pat(ADDR_W'(i));
      end
      @(negedge clk_i);
      load_en_i = 1'b0;
      ctrl.req(4'hE);
      expect_words(4'hE, 4);
      ctrl.req(4'h2);
      ctrl.req(4'h6);
      expect_words(4'h2, 8);
      single_clk_mode_i = 1'b1;
      ctrl.req(4'h5);
      expect_words(4'h5, 4);
      print_verdict();
   end
endmodule : ssr_read_port_tb
